// ### hw/dcq_array.sv
// Dual-port storage array of the queue: clocked write, combinational read
`timescale 1ns/1ps
module dcq_array #(
  parameter int DATA_W = dcq_pkg::DATA_W_DEF,
  parameter int ADDR_W = dcq_pkg::ADDR_W_DEF
) (
  input  wire logic              mclk,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data,
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic      [DATA_W-1:0] rd_data
);

  // Contents are deliberately not reset; reset clears the pointers, flags and output words, not the array
  logic [DATA_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

  store_word_a: assert property (
    @(posedge mclk) wr_en |=> mem[$past(wr_addr)] == $past(wr_data))
    else $error("written word not found in the array");

endmodule

// ### hw/dcq_irq.sv
// Sticky interrupt status, enable and clear registers with a level output
`timescale 1ns/1ps
module dcq_irq #(
  parameter int N = dcq_pkg::NUM_EV
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic [N-1:0] set_in,
  input  wire logic         clr_we,
  input  wire logic         en_we,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] enable,
  output logic              irq
);

  logic [N-1:0] status_ff;
  logic [N-1:0] nxt_status;
  logic [N-1:0] enable_ff;
  logic [N-1:0] nxt_enable;
  logic         irq_ff;
  logic         nxt_irq;

  always_comb begin
    // A new event beats a clear arriving in the same cycle
    nxt_status = (status_ff & ~(clr_we ? wdata : '0)) | set_in;
    nxt_enable = en_we ? wdata : enable_ff;
    nxt_irq    = |(nxt_status & nxt_enable);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_ff <= '0;
      enable_ff <= '0;
      irq_ff    <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      enable_ff <= nxt_enable;
      irq_ff    <= nxt_irq;
    end
  end

  assign status = status_ff;
  assign enable = enable_ff;
  assign irq    = irq_ff;

  set_wins_a: assert property (
    @(posedge mclk) disable iff (rst)
    (|set_in) |=> (status_ff & $past(set_in)) == $past(set_in))
    else $error("event lost against a clear");

endmodule

// ### hw/dcq_pkg.sv
// Shared constants of the single-clock queue: sizes, register map, field layout
package dcq_pkg;

  // ****************************************************************
  // Sizes and reset values
  // ****************************************************************
  localparam int DATA_W_DEF = 18;
  localparam int ADDR_W_DEF = 9;
  localparam int AE_LEVEL_RST = 12;
  localparam int AF_LEVEL_RST = 500;
  localparam logic CTRL_OUTREG_RST = 1'b0;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int BUS_AW = 8;
  localparam int BUS_DW = 32;

  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_AE_LEVEL   = 8'h08;
  localparam logic [7:0] REG_AF_LEVEL   = 8'h0c;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h10;
  localparam logic [7:0] REG_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h18;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_OUTREG_BIT = 0;
  localparam int ST_EMPTY_BIT    = 0;
  localparam int ST_AEMPTY_BIT   = 1;
  localparam int ST_AFULL_BIT    = 2;
  localparam int ST_FULL_BIT     = 3;
  localparam int ST_LEVEL_LSB    = 16;

  // Interrupt event bits
  localparam int EV_OVERFLOW  = 0;
  localparam int EV_UNDERFLOW = 1;
  localparam int EV_AFULL     = 2;
  localparam int EV_AEMPTY    = 3;
  localparam int NUM_EV       = 4;

endpackage

// ### hw/dcq_queue.sv
// Queue around a dual-port array with empty/full handshake flags and regs
`timescale 1ns/1ps

module dcq_queue #(
  parameter int DATA_W = dcq_pkg::DATA_W_DEF,
  parameter int ADDR_W = dcq_pkg::ADDR_W_DEF
) (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      write_request,
  input  wire logic [DATA_W-1:0]         write_word,
  input  wire logic                      read_request,
  input  wire logic                      read_pointer_restart,
  output logic      [DATA_W-1:0]         read_word,
  output logic                           empty_flag,
  output logic                           almost_empty_flag,
  output logic                           almost_full_flag,
  output logic                           full_flag,
  input  wire logic [dcq_pkg::BUS_AW-1:0] reg_addr,
  input  wire logic [dcq_pkg::BUS_DW-1:0] reg_wdata,
  input  wire logic                      reg_write,
  input  wire logic                      reg_read,
  output logic      [dcq_pkg::BUS_DW-1:0] reg_rdata,
  output logic                           irq
);

  localparam int PTR_W = ADDR_W + 1;
  localparam logic [PTR_W-1:0] DEPTH = PTR_W'(2**ADDR_W);
  localparam logic [PTR_W-1:0] AE_RST = PTR_W'(dcq_pkg::AE_LEVEL_RST);
  localparam logic [PTR_W-1:0] AF_RST = PTR_W'(dcq_pkg::AF_LEVEL_RST);

  // ****************************************************************
  // Pointers and fill level
  // ****************************************************************
  logic [PTR_W-1:0]  wr_ptr_ff;
  logic [PTR_W-1:0]  nxt_wr_ptr;
  logic [PTR_W-1:0]  rd_ptr_ff;
  logic [PTR_W-1:0]  nxt_rd_ptr;
  logic [PTR_W-1:0]  level;
  logic [PTR_W-1:0]  nxt_level;
  logic              arr_wr_en;
  logic              arr_rd_en;
  logic [DATA_W-1:0] mem_rdata;

  // Handshake flag state
  logic wr_empty_ff;
  logic nxt_wr_empty;
  logic full_ind_ff;
  logic nxt_full_ind;
  logic empty_flag_ff;
  logic nxt_empty_flag;
  logic full_flag_ff;
  logic nxt_full_flag;
  logic almost_empty_ff;
  logic nxt_almost_empty;
  logic almost_full_ff;
  logic nxt_almost_full;

  // Output path
  logic [DATA_W-1:0] stage_ff;
  logic [DATA_W-1:0] nxt_stage;
  logic [DATA_W-1:0] read_word_ff;
  logic [DATA_W-1:0] nxt_read_word;

  // Registers
  logic                       outreg_ff;
  logic                       nxt_outreg;
  logic [PTR_W-1:0]           ae_thr_ff;
  logic [PTR_W-1:0]           nxt_ae_thr;
  logic [PTR_W-1:0]           af_thr_ff;
  logic [PTR_W-1:0]           nxt_af_thr;
  logic [PTR_W-1:0]           eff_ae;
  logic [PTR_W-1:0]           eff_af;
  logic [dcq_pkg::BUS_DW-1:0] rdata_ff;
  logic [dcq_pkg::BUS_DW-1:0] nxt_rdata;
  logic [dcq_pkg::NUM_EV-1:0] ev_set;
  logic [dcq_pkg::NUM_EV-1:0] irq_status;
  logic [dcq_pkg::NUM_EV-1:0] irq_enable;
  logic                       irq_out;

  always_comb begin
    level      = wr_ptr_ff - rd_ptr_ff;
    // Level guards keep the pointers sane even if the flags lag
    arr_wr_en  = write_request && !full_flag_ff
                 && level != DEPTH;
    arr_rd_en  = read_request && !empty_flag_ff
                 && level != '0;
    nxt_wr_ptr = wr_ptr_ff + PTR_W'(arr_wr_en);
    if (read_pointer_restart) begin
      nxt_rd_ptr = '0;
    end else begin
      nxt_rd_ptr = rd_ptr_ff + PTR_W'(arr_rd_en);
    end
    nxt_level  = nxt_wr_ptr - nxt_rd_ptr;
  end

  dcq_array #(
    .DATA_W (DATA_W),
    .ADDR_W (ADDR_W)
  ) u_array (
    .mclk    (mclk),
    .wr_en   (arr_wr_en),
    .wr_addr (wr_ptr_ff[ADDR_W-1:0]),
    .wr_data (write_word),
    .rd_addr (rd_ptr_ff[ADDR_W-1:0]),
    .rd_data (mem_rdata)
  );

  // ****************************************************************
  // Flags
  // ****************************************************************
  always_comb begin
    // Thresholds are clamped so the ordering holds for any almost-full level above 0
    eff_af = (af_thr_ff > DEPTH) ? DEPTH : af_thr_ff;
    eff_ae = (ae_thr_ff >= eff_af) ? eff_af - 1'b1 : ae_thr_ff;
    nxt_wr_empty   = write_request ? (nxt_level == '0)
                                   : wr_empty_ff;
    nxt_full_ind   = read_request ? (nxt_level == DEPTH) : full_ind_ff;
    // Carried flags move only with their own side's request, which
    // is what costs the extra cycle on the first word
    nxt_empty_flag = read_request ? (wr_empty_ff || nxt_level == '0)
                                  : empty_flag_ff;
    nxt_full_flag  = write_request ? (full_ind_ff || nxt_level == DEPTH)
                                   : full_flag_ff;
    nxt_almost_empty = nxt_level <= eff_ae;
    nxt_almost_full  = nxt_level >= eff_af;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr_ff       <= '0;
      rd_ptr_ff       <= '0;
      wr_empty_ff     <= 1'b1;
      full_ind_ff     <= 1'b0;
      empty_flag_ff   <= 1'b1;
      full_flag_ff    <= 1'b0;
      almost_empty_ff <= 1'b1;
      almost_full_ff  <= 1'b0;
    end else begin
      wr_ptr_ff       <= nxt_wr_ptr;
      rd_ptr_ff       <= nxt_rd_ptr;
      wr_empty_ff     <= nxt_wr_empty;
      full_ind_ff     <= nxt_full_ind;
      empty_flag_ff   <= nxt_empty_flag;
      full_flag_ff    <= nxt_full_flag;
      almost_empty_ff <= nxt_almost_empty;
      almost_full_ff  <= nxt_almost_full;
    end
  end

  // ****************************************************************
  // Read data path
  // ****************************************************************
  always_comb begin
    nxt_stage = arr_rd_en ? mem_rdata : stage_ff;
    if (outreg_ff) begin
      nxt_read_word = read_request ? stage_ff
                                   : read_word_ff;
    end else begin
      nxt_read_word = arr_rd_en ? mem_rdata
                                : read_word_ff;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stage_ff     <= '0;
      read_word_ff <= '0;
    end else begin
      stage_ff     <= nxt_stage;
      read_word_ff <= nxt_read_word;
    end
  end

  // ****************************************************************
  // Register bus and interrupts
  // ****************************************************************
  always_comb begin
    ev_set = '0;
    ev_set[dcq_pkg::EV_OVERFLOW]  = write_request && !arr_wr_en;
    ev_set[dcq_pkg::EV_UNDERFLOW] = read_request && !arr_rd_en;
    ev_set[dcq_pkg::EV_AFULL]     = nxt_almost_full && !almost_full_ff;
    ev_set[dcq_pkg::EV_AEMPTY]    = nxt_almost_empty && !almost_empty_ff;
    nxt_outreg = outreg_ff;
    nxt_ae_thr = ae_thr_ff;
    nxt_af_thr = af_thr_ff;
    if (reg_write) begin
      case (reg_addr)
        dcq_pkg::REG_CTRL: begin
          nxt_outreg = reg_wdata[dcq_pkg::CTRL_OUTREG_BIT];
        end
        dcq_pkg::REG_AE_LEVEL: nxt_ae_thr = reg_wdata[PTR_W-1:0];
        dcq_pkg::REG_AF_LEVEL: nxt_af_thr = reg_wdata[PTR_W-1:0];
        default: ;
      endcase
    end
    nxt_rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        dcq_pkg::REG_CTRL: begin
          nxt_rdata[dcq_pkg::CTRL_OUTREG_BIT] = outreg_ff;
        end
        dcq_pkg::REG_STATUS: begin
          nxt_rdata[dcq_pkg::ST_EMPTY_BIT]  = empty_flag_ff;
          nxt_rdata[dcq_pkg::ST_AEMPTY_BIT] = almost_empty_ff;
          nxt_rdata[dcq_pkg::ST_AFULL_BIT]  = almost_full_ff;
          nxt_rdata[dcq_pkg::ST_FULL_BIT]   = full_flag_ff;
          nxt_rdata[dcq_pkg::ST_LEVEL_LSB +: PTR_W] = level;
        end
        dcq_pkg::REG_AE_LEVEL:   nxt_rdata[PTR_W-1:0] = ae_thr_ff;
        dcq_pkg::REG_AF_LEVEL:   nxt_rdata[PTR_W-1:0] = af_thr_ff;
        dcq_pkg::REG_IRQ_STATUS: nxt_rdata[dcq_pkg::NUM_EV-1:0] = irq_status;
        dcq_pkg::REG_IRQ_ENABLE: nxt_rdata[dcq_pkg::NUM_EV-1:0] = irq_enable;
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      outreg_ff <= dcq_pkg::CTRL_OUTREG_RST;
      ae_thr_ff <= AE_RST;
      af_thr_ff <= AF_RST;
      rdata_ff  <= '0;
    end else begin
      outreg_ff <= nxt_outreg;
      ae_thr_ff <= nxt_ae_thr;
      af_thr_ff <= nxt_af_thr;
      rdata_ff  <= nxt_rdata;
    end
  end

  dcq_irq #(
    .N (dcq_pkg::NUM_EV)
  ) u_irq (
    .mclk   (mclk),
    .rst    (rst),
    .set_in (ev_set),
    .clr_we (reg_write && reg_addr == dcq_pkg::REG_IRQ_CLEAR),
    .en_we  (reg_write && reg_addr == dcq_pkg::REG_IRQ_ENABLE),
    .wdata  (reg_wdata[dcq_pkg::NUM_EV-1:0]),
    .status (irq_status),
    .enable (irq_enable),
    .irq    (irq_out)
  );

  assign read_word         = read_word_ff;
  assign empty_flag        = empty_flag_ff;
  assign almost_empty_flag = almost_empty_ff;
  assign almost_full_flag  = almost_full_ff;
  assign full_flag         = full_flag_ff;
  assign reg_rdata         = rdata_ff;
  assign irq               = irq_out;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_arm;
    empty_flag_ff && !wr_empty_ff && level != '0 && read_request
      && !read_pointer_restart;
  endsequence

  sequence s_plain_first;
    s_arm ##0 !outreg_ff ##1 read_request && !outreg_ff;
  endsequence

  sequence s_reg_first;
    s_arm ##0 outreg_ff ##1 read_request && outreg_ff
      ##1 read_request && outreg_ff;
  endsequence

  read_advance_a: assert property (
    arr_rd_en && !read_pointer_restart |=>
      rd_ptr_ff == $past(rd_ptr_ff) + PTR_W'(1))
    else $error("read pointer did not advance");

  restart_ptr_a: assert property (
    read_pointer_restart |=> rd_ptr_ff == '0)
    else $error("restart did not clear read pointer");

  outreg_hold_a: assert property (
    outreg_ff && !read_request |=> $stable(read_word_ff))
    else $error("output register changed without read request");

  reset_state_a: assert property (
    $fell(rst) |-> wr_ptr_ff == '0 && rd_ptr_ff == '0 && empty_flag_ff
      && almost_empty_ff && !full_flag_ff && !almost_full_ff)
    else $error("bad state after reset");

  first_plain_a: assert property (
    s_plain_first |=> read_word_ff == $past(mem_rdata))
    else $error("first word not out after two cycles");

  empty_capture_a: assert property (
    !write_request |=> $stable(wr_empty_ff))
    else $error("empty indication moved without write");

  empty_carry_a: assert property (
    !read_request |=> $stable(empty_flag_ff))
    else $error("empty flag moved without read");

  empty_block_a: assert property (
    empty_flag_ff |-> !arr_rd_en)
    else $error("array read while empty flag set");

  full_block_a: assert property (
    full_flag_ff |-> !arr_wr_en ##1 $stable(wr_ptr_ff))
    else $error("write accepted while full");

  first_reg_a: assert property (
    s_reg_first |=> read_word_ff == $past(stage_ff))
    else $error("first word not out after three cycles");

  write_advance_a: assert property (
    arr_wr_en |=> wr_ptr_ff == $past(wr_ptr_ff) + PTR_W'(1))
    else $error("write pointer did not advance");

  afull_level_a: assert property (
    $stable(eff_af) |-> almost_full_ff == (level >= eff_af))
    else $error("almost full flag disagrees with level");

endmodule

// ### verification/dcq_user_side.sv
// Model of the user logic that feeds and drains the queue
`timescale 1ns/1ps
module dcq_user_side #(
  parameter int DATA_W = dcq_pkg::DATA_W_DEF
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [6:0]        wr_rate,
  input  wire logic [6:0]        rd_rate,
  output logic                   write_request,
  output logic      [DATA_W-1:0] write_word,
  output logic                   read_request
);
  // ****************************************************************
  // Request generation
  // ****************************************************************
  // Rates are percentages; below 100 the user stalls at random. The word
  // changes every cycle, so a refused write loses its word as it would
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      write_request <= 1'b0;
      read_request  <= 1'b0;
      write_word    <= '0;
    end else begin
      write_request <= ($urandom % 100) < wr_rate;
      read_request  <= ($urandom % 100) < rd_rate;
      write_word    <= DATA_W'($urandom);
    end
  end
endmodule

// ### verification/tb_top.sv
// Self-checking testbench of the queue with its register port
`timescale 1ns/1ps
module tb_top;
  localparam int         DW  = dcq_pkg::DATA_W_DEF;
  localparam logic [6:0] ALL = 7'h64;
  logic          mclk      = 1'b0;
  logic          rst       = 1'b1;
  logic [6:0]    wr_rate   = 7'h00;
  logic [6:0]    rd_rate   = 7'h00;
  logic          restart   = 1'b0;
  logic [7:0]    reg_addr  = 8'h00;
  logic [31:0]   reg_wdata = 32'h0;
  logic          reg_write = 1'b0;
  logic          reg_read  = 1'b0;
  logic          write_request, read_request, irq;
  logic          empty_flag, almost_empty_flag, almost_full_flag, full_flag;
  logic [DW-1:0] write_word, read_word, stage;
  logic [31:0]   reg_rdata;
  logic          outreg    = 1'b0;
  logic          stage_ok  = 1'b0;
  logic [DW-1:0] exp_q[$];
  logic [DW-1:0] saved_q[$];
  logic [63:0]   rexp_q[$];
  int            err_count = 0;
  int            n_checks  = 0;

  always #50 mclk = ~mclk;

  dcq_user_side user (.mclk(mclk), .rst(rst), .wr_rate(wr_rate),
    .rd_rate(rd_rate), .write_request(write_request),
    .write_word(write_word), .read_request(read_request));

  dcq_queue dut (.mclk(mclk), .rst(rst), .write_request(write_request),
    .write_word(write_word), .read_request(read_request),
    .read_pointer_restart(restart), .read_word(read_word),
    .empty_flag(empty_flag), .almost_empty_flag(almost_empty_flag),
    .almost_full_flag(almost_full_flag), .full_flag(full_flag),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_end(input string s);
    $display("test %s done, mismatches %0d", s, err_count);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Pre-edge values are taken in the active region, results 1 ns later
  always @(posedge mclk) begin : data_mon
    logic          rq, tk, wk;
    logic [DW-1:0] prev, ww, w;
    rq = read_request;
    tk = rq & ~empty_flag & ~restart & ~rst;
    wk = write_request & ~full_flag & ~rst;
    ww = write_word;
    prev = read_word;
    #1;
    if (wk) exp_q.push_back(ww);
    w = prev;
    if (tk && exp_q.size() == 0)
      check("spare read", 32'h1, 32'h0);
    else if (tk) w = exp_q.pop_front();
    if (rst) stage_ok = 1'b0;
    else if (!outreg)
      check("read_word", read_word, w);
    else if (!rq) check("held word", read_word, prev);
    else begin
      if (stage_ok) check("outreg word", read_word, stage);
      if (tk) stage = w;
      stage_ok = stage_ok | tk;
    end
  end

  always @(posedge mclk) begin : reg_mon
    logic        rr;
    logic [63:0] e;
    rr = reg_read;
    #1;
    if (rr) begin
      e = rexp_q.pop_front();
      check("reg_rdata", reg_rdata & e[63:32],
            e[31:0]);
    end
  end

  // ****************************************************************
  // Drivers
  // ****************************************************************
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] m);
    rexp_q.push_back({m, e & m});
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic push_n(input int n);
    wr_rate <= ALL;
    repeat (n) @(posedge mclk);
    wr_rate <= 7'h00;
    repeat (3) @(posedge mclk);
  endtask

  task automatic drain();
    rd_rate <= ALL;
    for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    rd_rate <= 7'h00;
    repeat (3) @(posedge mclk);
    check("drained", exp_q.size(), 32'h0);
  endtask

  task automatic check_reset();
    check("empty", empty_flag, 1'b1);
    check("almost empty", almost_empty_flag, 1'b1);
    check("full", full_flag, 1'b0);
    check("almost full", almost_full_flag, 1'b0);
    check("read_word", read_word, 18'h0);
    check("irq", irq, 1'b0);
    reg_rd(dcq_pkg::REG_STATUS, 32'h3, 32'h03ff000f);
    reg_rd(dcq_pkg::REG_AE_LEVEL, 32'(dcq_pkg::AE_LEVEL_RST),
           32'h3ff);
    reg_rd(dcq_pkg::REG_AF_LEVEL, 32'(dcq_pkg::AF_LEVEL_RST),
           32'h3ff);
    reg_rd(dcq_pkg::REG_CTRL, 32'h0, 32'h1);
    reg_rd(dcq_pkg::REG_IRQ_ENABLE, 32'h0, 32'hf);
    test_end("reset");
  endtask

  // Counts read requests until the first word appears
  task automatic first_word(input logic mode, input int n_exp);
    logic [DW-1:0] w;
    int            cnt;
    cnt = 0;
    reg_wr(dcq_pkg::REG_CTRL, {31'h0, mode});
    outreg = mode;
    push_n(1);
    w = exp_q[0];
    rd_rate <= ALL;
    for (int i = 0; i < 12; i++) begin
      @(posedge mclk);
      if (read_request) begin
        cnt++;
        #1;
        if (cnt == 1) check("empty 1st", empty_flag, 1'b0);
        if (read_word === w) break;
      end
    end
    check("first word", cnt, n_exp);
    rd_rate <= 7'h00;
    repeat (4) @(posedge mclk);
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    void'($urandom(32'h1825));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check_reset();
    reg_wr(dcq_pkg::REG_STATUS, 32'hffffffff);
    reg_rd(dcq_pkg::REG_STATUS, 32'h3, 32'h03ff000f);
    reg_rd(8'h1c, 32'h0, 32'hffffffff);
    test_end("registers");
    push_n(4);
    saved_q = exp_q;
    drain();
    restart <= 1'b1;
    @(posedge mclk);
    restart <= 1'b0;
    @(posedge mclk);
    exp_q = saved_q;
    drain();
    test_end("restart");
    first_word(1'b0, 2);
    first_word(1'b1, 3);
    reg_wr(dcq_pkg::REG_CTRL, 32'h0);
    outreg = 1'b0;
    test_end("first word");
    reg_wr(dcq_pkg::REG_AE_LEVEL, 32'h5);
    reg_wr(dcq_pkg::REG_AF_LEVEL, 32'h14);
    push_n(5);
    check("ae at 5", almost_empty_flag, 1'b1);
    push_n(1);
    check("ae at 6", almost_empty_flag, 1'b0);
    push_n(13);
    check("af at 19", almost_full_flag, 1'b0);
    push_n(1);
    check("af at 20", almost_full_flag, 1'b1);
    reg_rd(dcq_pkg::REG_STATUS, 32'h00140004, 32'h03ff000e);
    drain();
    // Level crossed 20 going up and 5 going down: both edge events stick
    reg_rd(dcq_pkg::REG_IRQ_STATUS, 32'hc, 32'hc);
    reg_wr(dcq_pkg::REG_AE_LEVEL, 32'(dcq_pkg::AE_LEVEL_RST));
    reg_wr(dcq_pkg::REG_AF_LEVEL, 32'(dcq_pkg::AF_LEVEL_RST));
    test_end("thresholds");
    push_n(540);
    check("full", full_flag, 1'b1);
    reg_rd(dcq_pkg::REG_STATUS, 32'h0200000c, 32'h03ff000e);
    reg_rd(dcq_pkg::REG_IRQ_STATUS, 32'h1, 32'h1);
    wr_rate <= 7'h3c;
    rd_rate <= 7'h3c;
    repeat (300) @(posedge mclk);
    wr_rate <= 7'h00;
    drain();
    test_end("fill");
    reg_wr(dcq_pkg::REG_IRQ_CLEAR, 32'hf);
    reg_rd(dcq_pkg::REG_IRQ_STATUS, 32'h0, 32'hf);
    reg_wr(dcq_pkg::REG_IRQ_ENABLE, 32'h2);
    rd_rate <= ALL;
    @(posedge mclk);
    rd_rate <= 7'h00;
    repeat (4) @(posedge mclk);
    check("irq set", irq, 1'b1);
    reg_rd(dcq_pkg::REG_IRQ_STATUS, 32'h2, 32'hf);
    reg_wr(dcq_pkg::REG_IRQ_ENABLE, 32'h0);
    @(posedge mclk);
    check("irq masked", irq, 1'b0);
    reg_wr(dcq_pkg::REG_IRQ_ENABLE, 32'h2);
    @(posedge mclk);
    check("irq unmasked", irq, 1'b1);
    reg_wr(dcq_pkg::REG_IRQ_CLEAR, 32'h2);
    @(posedge mclk);
    check("irq cleared", irq, 1'b0);
    test_end("interrupt");
    push_n(7);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    exp_q.delete();
    @(posedge mclk);
    check_reset();
    finish_test();
  end

  // Tests need about 1600 cycles
  initial begin
    #(30000 * 100);
    err_count++;
    finish_test();
  end
endmodule
